//--- core/uart_cfg_map.svh
// Register offsets, field positions, reset values and the extended page key of the UART setup block.
// Assumes a 3-bit register address and 8-bit register data.
`ifndef UART_CFG_MAP_SVH
`define UART_CFG_MAP_SVH

// Offsets on the 3-bit register address
`define OFS_DATA 3'h0
`define OFS_FIFO_CONTROL 3'h2
`define OFS_LINE_FORMAT 3'h3
`define OFS_MODEM_LINE_CONTROL 3'h4
`define OFS_DIVISOR_LOW 3'h0
`define OFS_DIVISOR_HIGH_BYTE 3'h1
`define OFS_DIVISOR_FRACTION 3'h2
`define OFS_LEVEL_REGISTER 3'h0
`define OFS_FEATURE_EXTENSION 3'h1
`define OFS_ENHANCED_FEATURES 3'h2
// Line format value that opens the extended register page
`define EXTENDED_PAGE_KEY 8'hbf

// Field positions
`define FCR_ENABLE 0
`define FCR_DMA_MODE 3
`define FCR_TX_SEL 4
`define FCR_RX_SEL 6
`define LCR_WORD 0
`define LCR_STOP 2
`define LCR_PARITY_ON 3
`define LCR_EVEN 4
`define LCR_FORCE 5
`define LCR_BREAK 6
`define LCR_DIVISOR 7
`define MCR_TERMINAL 0
`define MCR_REQUEST 1
`define MCR_AUX_ONE 2
`define MCR_INT_ENABLE 3
`define EFR_ENHANCED 4
`define EFR_AUTO_REQUEST 6
`define FEATURE_CONTROL_EXTENSION_HALF_DUPLEX 3
`define FEATURE_CONTROL_EXTENSION_TABLE 4
`define FEATURE_CONTROL_EXTENSION_LEVEL_DIR 7

// Reset values
`define RESET_BYTE 8'h00
`define RESET_LEVEL 8'h01

`endif

//--- core/uart_cfg_pkg.sv
// Types shared by the UART setup block and its decoders.
// Assumes the constants header supplies numbers; only types live here.
package uart_cfg_pkg;
    typedef enum logic [1:0] {
        TABLE_A = 2'b00,
        TABLE_B = 2'b01,
        TABLE_C = 2'b10,
        TABLE_D = 2'b11
    } trig_table_e;
    typedef logic [7:0] level_t;
endpackage : uart_cfg_pkg

//--- core/cfg_link_if.sv
// Carrier between the setup registers and the two decoders.
// Assumes all three modules share one clock and reset.
`timescale 1ns/1ps
interface cfg_link_if
    import uart_cfg_pkg::*;
(
    input wire logic clk,
    input wire logic rst
);
    trig_table_e table_sel;
    logic [1:0] rxSel;
    logic [1:0] txSel;
    level_t progRx;
    level_t progTx;
    level_t rxLevel;
    level_t txLevel;
    logic [7:0] lineFormat;
    logic [3:0] wordBits;
    logic [2:0] stopHalves;
    logic parityOn;
    logic parityFixed;
    logic parityValue;
    logic parityEven;

    modport ctrl (
        output table_sel, rxSel, txSel, progRx, progTx, lineFormat,
        input rxLevel, txLevel, wordBits, stopHalves, parityOn, parityFixed, parityValue,
        parityEven
    );
    modport trig (
        input clk, rst, table_sel, rxSel, txSel, progRx, progTx,
        output rxLevel, txLevel
    );
    modport fmt (
        input clk, rst, lineFormat,
        output wordBits, stopHalves, parityOn, parityFixed, parityValue, parityEven
    );
endinterface : cfg_link_if

//--- core/trigger_level_select.sv
// Maps trigger table and select bits to receive and transmit levels.
// Assumes selects are registered by the setup block on the same clock.
`timescale 1ns/1ps
`include "uart_cfg_map.svh"
module trigger_level_select
    import uart_cfg_pkg::*;
(
    cfg_link_if.trig link
);
    // Table lookup; one table governs both directions
    always_comb
    begin
        link.rxLevel = `RESET_LEVEL;
        link.txLevel = `RESET_LEVEL;
        case (link.table_sel)
            TABLE_A:
            begin
                case (link.rxSel)
                    2'b00: link.rxLevel = 8'h01;
                    2'b01: link.rxLevel = 8'h04;
                    2'b10: link.rxLevel = 8'h08;
                    default: link.rxLevel = 8'h0e;
                endcase
                link.txLevel = 8'h01;
            end
            TABLE_B:
            begin
                case (link.rxSel)
                    2'b00: link.rxLevel = 8'h08;
                    2'b01: link.rxLevel = 8'h10;
                    2'b10: link.rxLevel = 8'h18;
                    default: link.rxLevel = 8'h1c;
                endcase
                case (link.txSel)
                    2'b00: link.txLevel = 8'h10;
                    2'b01: link.txLevel = 8'h08;
                    2'b10: link.txLevel = 8'h18;
                    default: link.txLevel = 8'h1e;
                endcase
            end
            TABLE_C:
            begin
                case (link.rxSel)
                    2'b00: link.rxLevel = 8'h08;
                    2'b01: link.rxLevel = 8'h10;
                    2'b10: link.rxLevel = 8'h38;
                    default: link.rxLevel = 8'h3c;
                endcase
                case (link.txSel)
                    2'b00: link.txLevel = 8'h08;
                    2'b01: link.txLevel = 8'h10;
                    2'b10: link.txLevel = 8'h20;
                    default: link.txLevel = 8'h38;
                endcase
            end
            TABLE_D:
            begin
                // Programmed levels replace the select bits entirely
                link.rxLevel = link.progRx;
                link.txLevel = link.progTx;
            end
            default:
            begin
                link.rxLevel = `RESET_LEVEL;
                link.txLevel = `RESET_LEVEL;
            end
        endcase
    end

    AST_TABLE_A_TX: assert property (@(posedge link.clk) disable iff (link.rst)
        link.table_sel == TABLE_A |-> link.txLevel == 8'h01)
        else $error("table A transmit level is not one");
    AST_TABLE_C_RX: assert property (@(posedge link.clk) disable iff (link.rst)
        (link.table_sel == TABLE_C && link.rxSel == 2'b11) |-> link.rxLevel == 8'h3c)
        else $error("table C top receive level wrong");
endmodule : trigger_level_select

//--- core/char_format_decode.sv
// Decodes the line format byte into word length, stop length and parity mode.
// Assumes the byte is a register of the setup block on the same clock.
`timescale 1ns/1ps
`include "uart_cfg_map.svh"
module char_format_decode
    import uart_cfg_pkg::*;
(
    cfg_link_if.fmt link
);
    logic [1:0] word;
    logic forced;

    // Word and stop length; stop length is counted in half bit times
    always_comb
    begin
        word = link.lineFormat[`LCR_WORD +: 2];
        link.wordBits = 4'h5 + {2'b00, word};
        if (!link.lineFormat[`LCR_STOP])
            link.stopHalves = 3'h2;
        else if (word == 2'b00)
            link.stopHalves = 3'h3;
        else
            link.stopHalves = 3'h4;
    end

    // Parity shared by generation and checking
    always_comb
    begin
        forced = link.lineFormat[`LCR_FORCE];
        link.parityOn = link.lineFormat[`LCR_PARITY_ON];
        link.parityEven = link.lineFormat[`LCR_EVEN] & ~forced;
        link.parityFixed = link.parityOn & forced;
        link.parityValue = ~link.lineFormat[`LCR_EVEN];
    end

    AST_WORD_LEN: assert property (@(posedge link.clk) disable iff (link.rst)
        link.lineFormat[1:0] == 2'b10 |-> link.wordBits == 4'h7)
        else $error("seven bit word not decoded");
    AST_STOP_HALF: assert property (@(posedge link.clk) disable iff (link.rst)
        link.lineFormat[2:0] == 3'b100 |-> link.stopHalves == 3'h3)
        else $error("five bit word with long stop must give one and a half");
endmodule : char_format_decode

//--- core/uart_format_trigger_modem_ctrl.sv
// Setup registers of one UART channel: FIFO trigger levels, DMA request pins,
// character format, break, divisor access and modem control outputs.
// Assumes an asynchronous 8-bit host bus with active-low strobes and FIFO counts
// and serial data supplied by logic on clk.
`timescale 1ns/1ps
`include "uart_cfg_map.svh"
module uart_format_trigger_modem_ctrl
    import uart_cfg_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [2:0] busAddr,
    input wire logic [7:0] busDataIn,
    output logic [7:0] busDataOut,
    output logic busDataOe,
    input wire logic chipSelect_n,
    input wire logic readStrobe_n,
    input wire logic writeStrobe_n,
    input wire logic [6:0] txFifoCount,
    input wire logic [6:0] rxFifoCount,
    input wire logic [7:0] rxData,
    output logic [7:0] txData,
    output logic txDataWrite,
    output logic rxDataRead,
    input wire logic txSerial,
    output logic txPin,
    output logic [7:0] divisorLow,
    output logic [7:0] divisorHighByte,
    output logic [3:0] divisorFraction,
    output logic [3:0] wordBits,
    output logic [2:0] stopHalves,
    output logic parityOn,
    output logic parityEven,
    output logic parityFixed,
    output logic parityValue,
    output logic txInterrupt,
    output logic rxInterrupt,
    output logic transmitDmaRequest_n,
    output logic receiveDmaRequest_n,
    input wire logic autoRequest_n,
    input wire logic halfDuplexRequest_n,
    output logic terminalReady_n,
    output logic requestToSend_n,
    output logic auxOutputOne,
    output logic auxOutputTwo_n,
    input wire logic interruptIn,
    output logic interruptOut,
    output logic interruptOe
);
    // Bus pin synchronisers, two flops each
    logic [2:0] addrMeta, addrSync;
    logic [7:0] dataMeta, dataSync;
    logic [2:0] strobeMeta, strobeSync;
    logic writePrev, readPrev;
    logic writeTaken, readTaken, csActive, rdActive;

    // Register state
    logic [7:0] lineFormat;
    logic [7:0] modemLineControl;
    logic [7:0] enhancedFeatures;
    logic [7:0] featureControlExtension;
    logic dmaMode;
    logic [1:0] rxSel, txSel;
    level_t progRx, progTx;
    logic extPage, divPage, txWasAbove;

    cfg_link_if link (.clk(clk), .rst(rst));

    trigger_level_select u_trig (.link(link.trig));
    char_format_decode u_fmt (.link(link.fmt));

    // Pins are asynchronous to clk; logic only reads the second stage
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            addrMeta <= 3'h0;
            addrSync <= 3'h0;
            dataMeta <= 8'h00;
            dataSync <= 8'h00;
            strobeMeta <= 3'h7;
            strobeSync <= 3'h7;
        end
        else
        begin
            addrMeta <= busAddr;
            addrSync <= addrMeta;
            dataMeta <= busDataIn;
            dataSync <= dataMeta;
            strobeMeta <= {chipSelect_n, readStrobe_n, writeStrobe_n};
            strobeSync <= strobeMeta;
        end
    end

    // Strobe history for edge detection
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            writePrev <= 1'b0;
            readPrev <= 1'b0;
        end
        else
        begin
            writePrev <= ~strobeSync[0] & ~strobeSync[2];
            readPrev <= rdActive;
        end
    end

    // A write is taken at the end of the strobe, when data has settled
    always_comb
    begin
        csActive = ~strobeSync[2];
        rdActive = csActive & ~strobeSync[1];
        writeTaken = writePrev & strobeSync[0];
        readTaken = rdActive & ~readPrev;
        extPage = (lineFormat == `EXTENDED_PAGE_KEY);
        divPage = lineFormat[`LCR_DIVISOR] & ~extPage;
    end

    // Line format and modem control registers
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            lineFormat <= `RESET_BYTE;
            modemLineControl <= `RESET_BYTE;
        end
        else if (writeTaken)
        begin
            if (addrSync == `OFS_LINE_FORMAT)
                lineFormat <= dataSync;
            if (addrSync == `OFS_MODEM_LINE_CONTROL)
                modemLineControl <= dataSync;
        end
    end

    // Extended page registers, reachable only under the page key
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            enhancedFeatures <= `RESET_BYTE;
            featureControlExtension <= `RESET_BYTE;
            progRx <= `RESET_LEVEL;
            progTx <= `RESET_LEVEL;
        end
        else if (writeTaken && extPage)
        begin
            if (addrSync == `OFS_ENHANCED_FEATURES)
                enhancedFeatures <= dataSync;
            if (addrSync == `OFS_FEATURE_EXTENSION)
                featureControlExtension <= dataSync;
            if (addrSync == `OFS_LEVEL_REGISTER)
            begin
                // Direction bit decides which programmed level is loaded
                if (featureControlExtension[`FEATURE_CONTROL_EXTENSION_LEVEL_DIR])
                    progTx <= dataSync;
                else
                    progRx <= dataSync;
            end
        end
    end

    // FIFO control: ignored unless the enable bit is set in the same write
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            dmaMode <= 1'b0;
            rxSel <= 2'b00;
            txSel <= 2'b00;
        end
        else if (writeTaken && !extPage && !divPage && addrSync == `OFS_FIFO_CONTROL
                 && dataSync[`FCR_ENABLE])
        begin
            dmaMode <= dataSync[`FCR_DMA_MODE];
            rxSel <= dataSync[`FCR_RX_SEL +: 2];
            if (enhancedFeatures[`EFR_ENHANCED])
                txSel <= dataSync[`FCR_TX_SEL +: 2];
        end
    end

    // Divisor latches sit on offsets 0 to 2; low shares with the data registers, fraction with FIFO control
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            divisorLow <= 8'h00;
            divisorHighByte <= 8'h00;
            divisorFraction <= 4'h0;
        end
        else if (writeTaken && divPage)
        begin
            if (addrSync == `OFS_DIVISOR_LOW)
                divisorLow <= dataSync;
            if (addrSync == `OFS_DIVISOR_HIGH_BYTE)
                divisorHighByte <= dataSync;
            if (addrSync == `OFS_DIVISOR_FRACTION)
                divisorFraction <= dataSync[3:0];
        end
    end

    // Data register strobes toward the FIFOs; only with divisor access off
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            txData <= 8'h00;
            txDataWrite <= 1'b0;
            rxDataRead <= 1'b0;
        end
        else
        begin
            txDataWrite <= writeTaken && !divPage && !extPage && addrSync == `OFS_DATA;
            rxDataRead <= readTaken && !divPage && !extPage && addrSync == `OFS_DATA;
            if (writeTaken && !divPage && !extPage && addrSync == `OFS_DATA)
                txData <= dataSync;
        end
    end

    // Read data register; unmapped offsets read zero
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            busDataOut <= 8'h00;
        else if (readTaken)
        begin
            busDataOut <= 8'h00;
            if (addrSync == `OFS_LINE_FORMAT)
                busDataOut <= lineFormat;
            else if (addrSync == `OFS_MODEM_LINE_CONTROL)
                busDataOut <= modemLineControl;
            else if (extPage && addrSync == `OFS_ENHANCED_FEATURES)
                busDataOut <= enhancedFeatures;
            else if (extPage && addrSync == `OFS_FEATURE_EXTENSION)
                busDataOut <= featureControlExtension;
            else if (divPage && addrSync == `OFS_DIVISOR_LOW)
                busDataOut <= divisorLow;
            else if (divPage && addrSync == `OFS_DIVISOR_HIGH_BYTE)
                busDataOut <= divisorHighByte;
            else if (divPage && addrSync == `OFS_DIVISOR_FRACTION)
                busDataOut <= {4'h0, divisorFraction};
            else if (!divPage && !extPage && addrSync == `OFS_DATA)
                busDataOut <= rxData;
        end
    end

    // Drive data pins while a read stands, from the same edge that captures the data
    always_comb
    begin
        busDataOe = rdActive & readPrev;
    end

    // Settings out to the decoders; the table field is the single selection
    always_comb
    begin
        link.table_sel = trig_table_e'(featureControlExtension[`FEATURE_CONTROL_EXTENSION_TABLE +: 2]);
        link.rxSel = rxSel;
        link.txSel = txSel;
        link.progRx = progRx;
        link.progTx = progTx;
        link.lineFormat = lineFormat;
        wordBits = link.wordBits;
        stopHalves = link.stopHalves;
        parityOn = link.parityOn;
        parityEven = link.parityEven;
        parityFixed = link.parityFixed;
        parityValue = link.parityValue;
    end

    // Remembers whether the last reload took the FIFO to its level
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            txWasAbove <= 1'b0;
        else if ({1'b0, txFifoCount} >= link.txLevel)
            txWasAbove <= 1'b1;
        else if (txFifoCount == 7'h00)
            txWasAbove <= 1'b0;
    end

    // FIFO interrupts and DMA request pins
    always_comb
    begin
        txInterrupt = (txWasAbove && {1'b0, txFifoCount} < link.txLevel)
                      || txFifoCount == 7'h00;
        rxInterrupt = {1'b0, rxFifoCount} >= link.rxLevel;
        if (dmaMode)
        begin
            transmitDmaRequest_n = ~({1'b0, txFifoCount} < link.txLevel);
            receiveDmaRequest_n = ~rxInterrupt;
        end
        else
        begin
            transmitDmaRequest_n = txFifoCount != 7'h00;
            receiveDmaRequest_n = rxFifoCount == 7'h00;
        end
    end

    // Line and modem pins; break wins over any serial data
    always_comb
    begin
        txPin = txSerial & ~lineFormat[`LCR_BREAK];
        terminalReady_n = ~modemLineControl[`MCR_TERMINAL];
        if (featureControlExtension[`FEATURE_CONTROL_EXTENSION_HALF_DUPLEX])
            requestToSend_n = halfDuplexRequest_n;
        else if (enhancedFeatures[`EFR_AUTO_REQUEST])
            requestToSend_n = autoRequest_n;
        else
            requestToSend_n = ~modemLineControl[`MCR_REQUEST];
        auxOutputOne = modemLineControl[`MCR_AUX_ONE];
        auxOutputTwo_n = ~modemLineControl[`MCR_INT_ENABLE];
        interruptOe = modemLineControl[`MCR_INT_ENABLE];
        interruptOut = interruptIn & interruptOe;
    end

    AST_BREAK_LOW: assert property (@(posedge clk) disable iff (rst)
        lineFormat[`LCR_BREAK] |-> !txPin)
        else $error("transmit pin not held low during break");
    AST_TX_SEL_LOCK: assert property (@(posedge clk) disable iff (rst)
        !enhancedFeatures[`EFR_ENHANCED] |=> $stable(txSel))
        else $error("transmit select changed without enhanced functions");
    AST_FCR_ENABLE: assert property (@(posedge clk) disable iff (rst)
        (writeTaken && !dataSync[`FCR_ENABLE]) |=> $stable(dmaMode) && $stable(rxSel))
        else $error("fifo control programmed without enable bit");
    AST_DMA_NORMAL: assert property (@(posedge clk) disable iff (rst)
        !dmaMode |-> receiveDmaRequest_n == (rxFifoCount == 7'h00))
        else $error("receive request wrong in normal mode");
    AST_RX_INT: assert property (@(posedge clk) disable iff (rst)
        ({1'b0, rxFifoCount} >= link.rxLevel) |-> rxInterrupt)
        else $error("receive interrupt missing at trigger level");
    AST_TX_EMPTY: assert property (@(posedge clk) disable iff (rst)
        (txFifoCount == 7'h00) |-> txInterrupt)
        else $error("transmit interrupt missing on empty fifo");
    AST_TERMINAL: assert property (@(posedge clk) disable iff (rst)
        $rose(modemLineControl[`MCR_TERMINAL]) |-> !terminalReady_n)
        else $error("terminal ready pin not low after bit set");
    AST_INT_ENABLE: assert property (@(posedge clk) disable iff (rst)
        interruptOe |-> !auxOutputTwo_n && interruptOut == interruptIn)
        else $error("interrupt enable and second aux pin disagree");
    AST_LEVEL_LOAD: assert property (@(posedge clk) disable iff (rst)
        (writeTaken && extPage && addrSync == `OFS_LEVEL_REGISTER
         && !featureControlExtension[`FEATURE_CONTROL_EXTENSION_LEVEL_DIR]) |=> progRx == $past(dataSync))
        else $error("receive level register not loaded");
    AST_DIV_WRITE: assert property (@(posedge clk) disable iff (rst)
        (writeTaken && !divPage && addrSync == `OFS_DIVISOR_LOW) |=> $stable(divisorLow))
        else $error("divisor changed with divisor access off");
endmodule : uart_format_trigger_modem_ctrl

//--- test/far_end_line.sv
// Far end of the serial line: measures how long the line has been held at space.
// Assumes one clock shared with the block and a line that idles high.
`timescale 1ns/1ps
module far_end_line
(
    input wire logic clk,
    input wire logic txPin,
    output logic [7:0] spaceRun
);
    // Saturates so a long break never wraps back to zero
    always_ff @(posedge clk)
    begin
        spaceRun <= txPin ? 8'h00 : spaceRun + {7'h0, spaceRun != 8'hff};
    end
endmodule : far_end_line

//--- test/tb_top.sv
// Self-checking bench for the UART setup block, inputs driven on the falling edge.
// Assumes the far end only watches the line; FIFO counts come from the bench.
`timescale 1ns/1ps
`include "uart_cfg_map.svh"
module tb_top;
    logic clk, rst, busDataOe, chipSelect_n, readStrobe_n, writeStrobe_n, txDataWrite;
    logic rxDataRead, txSerial, txPin, parityOn, parityEven, parityFixed, parityValue;
    logic txInterrupt, rxInterrupt, transmitDmaRequest_n, receiveDmaRequest_n;
    logic autoRequest_n, halfDuplexRequest_n, terminalReady_n, requestToSend_n;
    logic auxOutputOne, auxOutputTwo_n, interruptIn, interruptOut, interruptOe;
    logic [2:0] busAddr, stopHalves;
    logic [3:0] divisorFraction, wordBits;
    logic [6:0] txFifoCount, rxFifoCount;
    logic [7:0] busDataIn, busDataOut, rxData, txData, divisorLow, divisorHighByte;
    logic [7:0] v, e, g, spaceRun;
    logic [7:0] expQ[$];
    logic [15:0] seed = 16'hf507;
    // Last four entries are the programmed levels loaded for table D
    logic [6:0] rxLv [16] = '{7'h01, 7'h04, 7'h08, 7'h0e, 7'h08, 7'h10, 7'h18, 7'h1c,
        7'h08, 7'h10, 7'h38, 7'h3c, 7'h20, 7'h20, 7'h20, 7'h20};
    logic [6:0] txLv [16] = '{7'h01, 7'h01, 7'h01, 7'h01, 7'h10, 7'h08, 7'h18, 7'h1e,
        7'h08, 7'h10, 7'h20, 7'h38, 7'h05, 7'h05, 7'h05, 7'h05};
    int pulses = 0;
    int errCount = 0;
    int samplesChecked = 0;
    int i, t, s;

    uart_format_trigger_modem_ctrl uart_format_trigger_modem_ctrl_i (.*);
    far_end_line far_end_line_i (.*);

    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : lfsr

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samplesChecked++;
        if (got !== exp)
        begin
            errCount++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Strobes held 6 clocks and chip select 4 more, to outlast the synchroniser
    task automatic bus(input logic wr, input logic [2:0] a, input logic [7:0] d);
        @(negedge clk);
        busAddr = a;
        busDataIn = d;
        chipSelect_n = 1'b0;
        writeStrobe_n = !wr;
        readStrobe_n = wr;
        repeat (6) @(negedge clk);
        writeStrobe_n = 1'b1;
        readStrobe_n = 1'b1;
        repeat (4) @(negedge clk);
        chipSelect_n = 1'b1;
        repeat (3) @(negedge clk);
    endtask : bus

    task automatic results;
        $display("checks %0d mismatches %0d", samplesChecked, errCount);
        if (errCount == 0 && samplesChecked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : results

    // Clock
    always #12.5 clk = !clk;

    // Read data pairs with the oldest note once the block drives the bus
    always @(posedge busDataOe)
    begin
        #1;
        chk(busDataOut, expQ.pop_front());
    end

    // Counts data-register strobes; sampled off the edge that launches them
    always @(negedge clk)
        if (txDataWrite || rxDataRead)
            pulses++;

    // Watchdog
    initial
    begin
        #200us;
        errCount++;
        results();
    end

    // Main sequence
    initial
    begin
        clk = 1'b0;
        {rst, chipSelect_n, readStrobe_n, writeStrobe_n} = 4'hf;
        {txSerial, autoRequest_n, halfDuplexRequest_n, interruptIn} = 4'he;
        {busAddr, busDataIn, rxData, txFifoCount, rxFifoCount} = 33'h0;
        repeat (16) @(negedge clk);
        rst = 1'b0;
        chk({terminalReady_n, requestToSend_n, auxOutputTwo_n, interruptOe, wordBits}, 8'he5);
        chk({5'h0, stopHalves}, 8'h02);
        for (i = 0; i < 6; i++)
        begin
            seed = lfsr(seed);
            v = {1'b0, i[0], seed[5:0]};
            rxData = seed[15:8];
            bus(1'b1, `OFS_LINE_FORMAT, v);
            e = {4'h5 + {2'h0, v[1:0]}, 1'b0, !v[2] ? 3'h2 : (v[1:0] == 2'h0 ? 3'h3 : 3'h4)};
            chk({wordBits, 1'b0, stopHalves}, e);
            e = {v[3], v[3] & v[5], v[3] & (v[5] ^ v[4]), !v[6], v[6], 3'h0};
            g = {parityOn, v[3] & parityFixed, v[3] & (v[5] ? parityValue : parityEven), 5'h0};
            chk({g[7:5], txPin, spaceRun != 8'h00, 3'h0}, e);
            expQ.push_back(v);
            bus(1'b0, `OFS_LINE_FORMAT, 8'h00);
        end
        $display("test line format done");
        for (i = 0; i < 4; i++)
        begin
            seed = lfsr(seed);
            v = {4'h0, seed[3:0]};
            interruptIn = seed[4];
            bus(1'b1, `OFS_MODEM_LINE_CONTROL, v);
            g = {terminalReady_n, requestToSend_n, auxOutputOne, auxOutputTwo_n, interruptOe, 3'h0};
            g[2] = interruptOut;
            chk(g, {!v[0], !v[1], v[2], !v[3], v[3], v[3] & interruptIn, 2'h0});
            expQ.push_back(v);
            bus(1'b0, `OFS_MODEM_LINE_CONTROL, 8'h00);
        end
        $display("test modem control done");
        seed = lfsr(seed);
        bus(1'b1, `OFS_DATA, seed[7:0]);
        chk(txData, seed[7:0]);
        expQ.push_back(rxData);
        bus(1'b0, `OFS_DATA, 8'h00);
        chk(8'(pulses), 8'h02);
        bus(1'b1, `OFS_LINE_FORMAT, 8'h80);
        seed = lfsr(seed);
        bus(1'b1, `OFS_DIVISOR_LOW, seed[7:0]);
        chk(divisorLow, seed[7:0]);
        bus(1'b1, `OFS_DIVISOR_HIGH_BYTE, seed[15:8]);
        bus(1'b1, `OFS_DIVISOR_FRACTION, seed[7:0]);
        chk(divisorHighByte, seed[15:8]);
        chk({4'h0, divisorFraction}, {4'h0, seed[3:0]});
        expQ.push_back(seed[7:0]);
        bus(1'b0, `OFS_DIVISOR_LOW, 8'h00);
        $display("test divisor done");
        for (t = 0; t < 4; t++)
        begin
            bus(1'b1, `OFS_LINE_FORMAT, `EXTENDED_PAGE_KEY);
            bus(1'b1, `OFS_ENHANCED_FEATURES, 8'h10);
            bus(1'b1, `OFS_FEATURE_EXTENSION, 8'h30);
            bus(1'b1, `OFS_LEVEL_REGISTER, 8'h20);
            bus(1'b1, `OFS_FEATURE_EXTENSION, {2'h2, t[1:0], 4'h0});
            bus(1'b1, `OFS_LEVEL_REGISTER, 8'h05);
            bus(1'b1, `OFS_LINE_FORMAT, 8'h00);
            for (s = 0; s < 4; s++)
            begin
                // An empty FIFO forgets the previous reload before each level change
                txFifoCount = 7'h0;
                bus(1'b1, `OFS_FIFO_CONTROL, {s[1:0], s[1:0], 4'h9});
                for (i = 0; i < 3; i++)
                begin
                    rxFifoCount = rxLv[t * 4 + s] - 7'h1 + {6'h0, i == 1};
                    txFifoCount = txLv[t * 4 + s] - 7'h1 + {6'h0, i == 1};
                    @(negedge clk);
                    g = {4'h0, txInterrupt, rxInterrupt, receiveDmaRequest_n, transmitDmaRequest_n};
                    e = {4'h0, i == 2 || (i == 0 && txLv[t * 4 + s] == 7'h1), i == 1, i != 1, i == 1};
                    chk(g, e);
                end
            end
        end
        // Transmit select must stay at 3 once enhanced functions are off
        bus(1'b1, `OFS_LINE_FORMAT, `EXTENDED_PAGE_KEY);
        bus(1'b1, `OFS_ENHANCED_FEATURES, 8'h00);
        bus(1'b1, `OFS_FEATURE_EXTENSION, 8'h10);
        bus(1'b1, `OFS_LINE_FORMAT, 8'h00);
        {rxFifoCount, txFifoCount} = {7'h08, 7'h1d};
        bus(1'b1, `OFS_FIFO_CONTROL, 8'h09);
        chk({6'h0, rxInterrupt, transmitDmaRequest_n}, 8'h02);
        bus(1'b1, `OFS_FIFO_CONTROL, 8'h01);
        chk({6'h0, transmitDmaRequest_n, receiveDmaRequest_n}, 8'h02);
        $display("test trigger levels done");
        results();
    end
endmodule : tb_top
